// File: hdl/adcsc_top.sv
`timescale 1ns/1ns
module adcsc_top
  import adcsc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        standby,
  input  wire logic [9:0]  sar_data,
  output      logic [2:0]  analog_sel,
  output      logic        sample_en,
  output      logic        conv_busy,
  output      logic        conv_end_irq
);

  adcsc_regs_t   r_r;
  adcsc_regs_t   r_nxt;
  adcsc_timing_t tm;
  logic          acc;
  logic          wr;
  logic          rd;
  logic          wr_ctl;
  logic          wr_mc;
  logic          rd_res;
  logic          run_ok;
  logic          done;
  logic          hit;
  logic [7:0]    wdat;
  logic          rd_setup;
  adcsc_timing_t tm_w;

  // ==========================================================
  // APB decode
  // ==========================================================
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  // Read data captured in setup so it stands at the access edge
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign wdat    = pwdata[7:0];
  assign wr_mc   = wr & (paddr == ADCSC_MODE_OFS | paddr == ADCSC_CHAN_OFS);
  assign wr_ctl  = wr_mc | (wr & (paddr == ADCSC_PFM_OFS |
                                  paddr == ADCSC_PFT_OFS));
  assign rd_res  = rd & (paddr == ADCSC_RES_OFS);
  assign pslverr = acc & ~(paddr == ADCSC_MODE_OFS | paddr == ADCSC_CHAN_OFS |
                           paddr == ADCSC_PFM_OFS | paddr == ADCSC_PFT_OFS |
                           paddr == ADCSC_RES_OFS | paddr == ADCSC_FLAG_OFS |
                           paddr == ADCSC_STAT_OFS);

  assign run_ok = r_r.mode[ADCSC_START_BIT] & ~standby;
  assign tm     = adcsc_timing(r_r.mode[ADCSC_FR_LSB +: 3]);
  // Restart takes the code being written, not the old one
  assign tm_w   = adcsc_timing((wr && paddr == ADCSC_MODE_OFS) ?
                               wdat[ADCSC_FR_LSB +: 3] :
                               r_r.mode[ADCSC_FR_LSB +: 3]);
  assign done   = (r_r.state == ADCSC_CONV) & (r_r.cnt == ADCSC_ONE);

  assign hit = ~r_r.powerfail_mode_reg[ADCSC_POWERFAIL_ENABLE_BIT_BIT] |
               (r_r.powerfail_mode_reg[ADCSC_POWERFAIL_COMPARE_SEL_BIT] ? (sar_data[9:2] <  r_r.powerfail_threshold_reg)
                                        : (sar_data[9:2] >= r_r.powerfail_threshold_reg));

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    r_nxt     = r_r;
    r_nxt.irq = 1'b0;
    if (rd_setup) begin
      case (paddr)
        ADCSC_MODE_OFS: r_nxt.prdata = {24'h000000, r_r.mode};
        ADCSC_CHAN_OFS: r_nxt.prdata = {29'h00000000, r_r.chan};
        ADCSC_PFM_OFS:  r_nxt.prdata = {24'h000000, r_r.powerfail_mode_reg};
        ADCSC_PFT_OFS:  r_nxt.prdata = {24'h000000, r_r.powerfail_threshold_reg};
        ADCSC_RES_OFS:  r_nxt.prdata = {22'h000000, r_r.result};
        ADCSC_FLAG_OFS: r_nxt.prdata = {31'h00000000, r_r.flag};
        ADCSC_STAT_OFS: r_nxt.prdata = {30'h00000000, r_r.state};
        default:        r_nxt.prdata = 32'h00000000;
      endcase
    end
    if (r_r.pend) begin
      r_nxt.pend   = 1'b0;
      r_nxt.result = r_r.pend_val;
      if (r_r.pend_hit) begin
        r_nxt.irq = 1'b1;
      end
    end
    // Sequencer
    case (r_r.state)
      ADCSC_IDLE: begin
        if (run_ok) begin
          r_nxt.state = ADCSC_DELAY;
          r_nxt.cnt   = tm.dly;
        end
      end
      ADCSC_DELAY: begin
        if (r_r.cnt == ADCSC_ONE) begin
          r_nxt.state = ADCSC_SAMP;
          r_nxt.cnt   = tm.samp;
        end else begin
          r_nxt.cnt = r_r.cnt - ADCSC_ONE;
        end
      end
      ADCSC_SAMP: begin
        if (r_r.cnt == ADCSC_ONE) begin
          r_nxt.state = ADCSC_CONV;
          r_nxt.cnt   = tm.conv - tm.samp;
        end else begin
          r_nxt.cnt = r_r.cnt - ADCSC_ONE;
        end
      end
      ADCSC_CONV: begin
        if (r_r.cnt == ADCSC_ONE) begin
          r_nxt.state = ADCSC_SAMP;
          r_nxt.cnt   = tm.samp;
          if (!wr_mc) begin
            if (rd_res) begin
              r_nxt.pend     = 1'b1;
              r_nxt.pend_val = sar_data;
              r_nxt.pend_hit = hit;
            end else begin
              r_nxt.result = sar_data;
              r_nxt.irq    = hit;
            end
          end
        end else begin
          r_nxt.cnt = r_r.cnt - ADCSC_ONE;
        end
      end
      default: begin
        r_nxt.state = ADCSC_IDLE;
      end
    endcase
    if (wr_ctl && r_r.state != ADCSC_IDLE) begin
      r_nxt.state = ADCSC_SAMP;
      r_nxt.cnt   = tm_w.samp;
    end
    if (wr) begin
      case (paddr)
        ADCSC_MODE_OFS: r_nxt.mode = wdat;
        ADCSC_CHAN_OFS: r_nxt.chan = wdat[2:0];
        ADCSC_PFM_OFS:  r_nxt.powerfail_mode_reg  = wdat;
        ADCSC_PFT_OFS:  r_nxt.powerfail_threshold_reg  = wdat;
        default:        r_nxt.flag = r_r.flag & ~pwdata[0];
      endcase
      if (paddr == ADCSC_MODE_OFS && !wdat[ADCSC_START_BIT]) begin
        r_nxt.state = ADCSC_IDLE;
      end
    end
    if (!run_ok) begin
      r_nxt.state = ADCSC_IDLE;
      r_nxt.pend  = 1'b0;
    end
    if (r_nxt.irq) begin
      r_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '{state: ADCSC_IDLE, mode: ADCSC_MODE_RST,
               chan: ADCSC_CHAN_RST, result: ADCSC_RES_RST,
               pend_val: ADCSC_RES_RST, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign prdata       = r_r.prdata;
  assign analog_sel   = r_r.chan;
  assign sample_en    = (r_r.state == ADCSC_SAMP);
  assign conv_busy    = (r_r.state != ADCSC_IDLE);
  // One-cycle pulse; the sticky flag keeps the history
  assign conv_end_irq = r_r.irq;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      !run_ok |=> r_r.state == ADCSC_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("not stopped");

  property p_delay;
    @(posedge pclk) disable iff (!presetn)
      (r_r.state == ADCSC_IDLE && run_ok && !wr) |=>
        r_r.state == ADCSC_DELAY && r_r.cnt == tm.dly;
  endproperty
  a_delay: assert property (p_delay) else $error("bad delay");

  property p_samp;
    @(posedge pclk) disable iff (!presetn)
      $rose(sample_en) |-> r_r.cnt == tm.samp;
  endproperty
  a_samp: assert property (p_samp) else $error("bad sample");

  property p_cont;
    @(posedge pclk) disable iff (!presetn)
      (done && run_ok && !wr) |=> sample_en;
  endproperty
  a_cont: assert property (p_cont) else $error("no repeat");

  property p_wrwin;
    @(posedge pclk) disable iff (!presetn)
      (done && wr_mc) |=> !conv_end_irq && $stable(r_r.result);
  endproperty
  a_wrwin: assert property (p_wrwin) else $error("write lost");

  property p_rdfirst;
    @(posedge pclk) disable iff (!presetn)
      (done && rd_res && !wr_mc && run_ok) |=>
        $stable(r_r.result) ##1 (r_r.result == $past(sar_data, 2));
  endproperty
  a_rdfirst: assert property (p_rdfirst) else $error("read order");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      conv_end_irq |-> r_r.flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_pf;
    @(posedge pclk) disable iff (!presetn)
      (done && !wr && !rd_res && run_ok && r_r.powerfail_mode_reg[ADCSC_POWERFAIL_ENABLE_BIT_BIT] &&
       !r_r.powerfail_mode_reg[ADCSC_POWERFAIL_COMPARE_SEL_BIT] && sar_data[9:2] < r_r.powerfail_threshold_reg) |=>
        !conv_end_irq;
  endproperty
  a_pf: assert property (p_pf) else $error("bad compare");

  property p_chflag;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == ADCSC_CHAN_OFS && r_r.flag) |=> r_r.flag;
  endproperty
  a_chflag: assert property (p_chflag) else $error("flag cleared");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      (wr_ctl && paddr != ADCSC_MODE_OFS && conv_busy && run_ok) |=>
        sample_en && r_r.cnt == tm.samp;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");

  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
      conv_end_irq |=> !conv_end_irq;
  endproperty
  a_pulse: assert property (p_pulse) else $error("irq too long");

  c_conv:  cover property (@(posedge pclk) disable iff (!presetn)
             conv_end_irq);
  c_rd:    cover property (@(posedge pclk) disable iff (!presetn)
             done && rd_res);
  c_abort: cover property (@(posedge pclk) disable iff (!presetn)
             wr_ctl && conv_busy);
  c_pend:  cover property (@(posedge pclk) disable iff (!presetn)
             r_r.pend);
  c_nohit: cover property (@(posedge pclk) disable iff (!presetn)
             done && !hit);

endmodule : adcsc_top

// File: hdl/adcsc_pkg.sv
package adcsc_pkg;

  // ==========================================================
  // Register map (byte addresses, chosen)
  // ==========================================================
  localparam logic [11:0] ADCSC_MODE_OFS   = 12'h000;
  localparam logic [11:0] ADCSC_CHAN_OFS   = 12'h004;
  localparam logic [11:0] ADCSC_PFM_OFS    = 12'h008;
  localparam logic [11:0] ADCSC_PFT_OFS    = 12'h00C;
  localparam logic [11:0] ADCSC_RES_OFS    = 12'h010;
  localparam logic [11:0] ADCSC_FLAG_OFS   = 12'h014;
  localparam logic [11:0] ADCSC_STAT_OFS   = 12'h018;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int ADCSC_START_BIT  = 7;
  localparam int ADCSC_ENABLE_BIT = 0;
  localparam int ADCSC_FR_LSB     = 3;
  localparam int ADCSC_POWERFAIL_ENABLE_BIT_BIT   = 7;
  localparam int ADCSC_POWERFAIL_COMPARE_SEL_BIT   = 6;

  localparam logic [7:0]  ADCSC_MODE_RST = 8'h00;
  localparam logic [2:0]  ADCSC_CHAN_RST = 3'h0;
  localparam logic [9:0]  ADCSC_RES_RST  = 10'h000;

  // ==========================================================
  // Timing in main-oscillator periods (one pclk each)
  // ==========================================================
  localparam logic [8:0] ADCSC_CONV_000 = 9'd288;
  localparam logic [8:0] ADCSC_SAMP_000 = 9'd40;
  localparam logic [8:0] ADCSC_DLY_000  = 9'd32;
  localparam logic [8:0] ADCSC_CONV_001 = 9'd240;
  localparam logic [8:0] ADCSC_SAMP_001 = 9'd32;
  localparam logic [8:0] ADCSC_DLY_001  = 9'd28;
  localparam logic [8:0] ADCSC_CONV_010 = 9'd192;
  localparam logic [8:0] ADCSC_SAMP_010 = 9'd24;
  localparam logic [8:0] ADCSC_DLY_010  = 9'd24;
  localparam logic [8:0] ADCSC_CONV_100 = 9'd144;
  localparam logic [8:0] ADCSC_SAMP_100 = 9'd20;
  localparam logic [8:0] ADCSC_DLY_100  = 9'd16;
  localparam logic [8:0] ADCSC_CONV_101 = 9'd120;
  localparam logic [8:0] ADCSC_SAMP_101 = 9'd16;
  localparam logic [8:0] ADCSC_DLY_101  = 9'd14;
  localparam logic [8:0] ADCSC_CONV_110 = 9'd96;
  localparam logic [8:0] ADCSC_SAMP_110 = 9'd12;
  localparam logic [8:0] ADCSC_DLY_110  = 9'd12;
  localparam logic [8:0] ADCSC_ONE      = 9'd1;

  typedef enum logic [1:0] {
    ADCSC_IDLE  = 2'b00,
    ADCSC_DELAY = 2'b01,
    ADCSC_SAMP  = 2'b11,
    ADCSC_CONV  = 2'b10
  } adcsc_state_t;

  typedef struct packed {
    logic [8:0] conv;
    logic [8:0] samp;
    logic [8:0] dly;
  } adcsc_timing_t;

  typedef struct packed {
    adcsc_state_t state;
    logic [8:0]   cnt;
    logic [7:0]   mode;
    logic [2:0]   chan;
    logic [7:0]   powerfail_mode_reg;
    logic [7:0]   powerfail_threshold_reg;
    logic [9:0]   result;
    logic         flag;
    logic         irq;
    logic         pend;
    logic [9:0]   pend_val;
    logic         pend_hit;
    logic [31:0]  prdata;
  } adcsc_regs_t;

  function automatic adcsc_timing_t adcsc_timing(input logic [2:0] code);
    adcsc_timing_t t;
    t = '{conv: ADCSC_CONV_000, samp: ADCSC_SAMP_000, dly: ADCSC_DLY_000};
    case (code)
      3'h1: t = '{ADCSC_CONV_001, ADCSC_SAMP_001, ADCSC_DLY_001};
      3'h2: t = '{ADCSC_CONV_010, ADCSC_SAMP_010, ADCSC_DLY_010};
      3'h4: t = '{ADCSC_CONV_100, ADCSC_SAMP_100, ADCSC_DLY_100};
      3'h5: t = '{ADCSC_CONV_101, ADCSC_SAMP_101, ADCSC_DLY_101};
      3'h6: t = '{ADCSC_CONV_110, ADCSC_SAMP_110, ADCSC_DLY_110};
      default: t = '{ADCSC_CONV_000, ADCSC_SAMP_000, ADCSC_DLY_000};
    endcase
    return t;
  endfunction : adcsc_timing

endpackage : adcsc_pkg

// File: test/adcsc_analog_src.sv
`timescale 1ns/1ns
module adcsc_analog_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [2:0]  analog_sel,
  input  wire logic        sample_en,
  input  wire logic [79:0] levels,
  output      logic [9:0]  sar_data
);
  // ==========================================================
  // Sample and hold
  // ==========================================================
  // no digital port shares these pins
  // held through conversion
  // Charge follows the input only while sampling, then holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_data <= 10'h000;
    end else if (sample_en) begin
      sar_data <= levels[analog_sel*10 +: 10];
    end
  end
endmodule : adcsc_analog_src

// File: test/tb_adc_sequencing_control.sv
`timescale 1ns/1ns
module tb_adc_sequencing_control import adcsc_pkg::*;;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        standby = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, sample_en, conv_busy, conv_end_irq;
  logic [2:0]  analog_sel, ch;
  logic [9:0]  sar_data;
  logic [79:0] levels = '0;
  int          errors = 0;
  int          num_checks = 0;
  int          seed, n, m, i;
  int cd[6] = '{0, 1, 2, 4, 5, 6};
  int dmn[6] = '{32, 28, 24, 16, 14, 12};
  int dmx[6] = '{36, 32, 28, 18, 16, 14};
  int sp[6] = '{40, 32, 24, 20, 16, 12};
  int cv[6] = '{288, 240, 192, 144, 120, 96};
  logic [7:0] pfv[4] = '{8'h80, 8'h81, 8'h81, 8'h80};

  always #5 pclk = ~pclk;

  adcsc_top u_adcsc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby(standby), .sar_data(sar_data), .analog_sel(analog_sel),
    .sample_en(sample_en), .conv_busy(conv_busy),
    .conv_end_irq(conv_end_irq));
  adcsc_analog_src u_adcsc_analog_src (.pclk(pclk), .presetn(presetn),
    .analog_sel(analog_sel), .sample_en(sample_en), .levels(levels),
    .sar_data(sar_data));

  // ==========================================================
  // Checks and bus
  // ==========================================================
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("Error at %0t: got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) errors++;
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_sig(input int sel, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      #1 n++;
    end while ((sel ? sample_en : conv_end_irq) !== 1'b1 && n <= lim);
  endtask : wait_sig

  function automatic logic pf_hit(input logic [9:0] r, input logic [7:0] t,
                                  input logic cm);
    return cm ? (r[9:2] < t) : (r[9:2] >= t);
  endfunction : pf_hit

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    seed = 89385;
    for (i = 0; i < 8; i++) levels[i*10 +: 10] = 10'($random(seed));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 7; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk_val(rd, 32'h0);
    end
    apb(1'b0, 12'h01C, 32'h0);
    chk_val({31'h0, err}, 32'h1);
    $display("reset and map test done");
    for (i = 0; i < 6; i++) begin
      ch = 3'($random(seed));
      apb(1'b1, ADCSC_MODE_OFS, 32'h0);
      apb(1'b1, ADCSC_CHAN_OFS, {29'h0, ch});
      apb(1'b1, ADCSC_FLAG_OFS, 32'h1);
      apb(1'b1, ADCSC_MODE_OFS, 32'(8'h81 | (cd[i] << 3)));
      wait_sig(1, 60);
      chk_rng(n, dmn[i], dmx[i]);
      m = 0;
      while (sample_en === 1'b1 && m < 60) begin
        @(posedge pclk);
        #1 m++;
      end
      chk_rng(m, sp[i], sp[i]);
      wait_sig(0, 400);
      wait_sig(0, 400);
      chk_rng(n, cv[i], cv[i]);
      chk_val({29'h0, analog_sel}, {29'h0, ch});
      apb(1'b0, ADCSC_RES_OFS, 32'h0);
      chk_val(rd, {22'h0, levels[ch*10 +: 10]});
      apb(1'b0, ADCSC_FLAG_OFS, 32'h0);
      chk_val(rd, 32'h1);
    end
    $display("timing per code test done");
    ch = ch + 3'h1;
    wait_sig(0, 200);
    apb(1'b1, ADCSC_CHAN_OFS, {29'h0, ch});
    apb(1'b0, ADCSC_FLAG_OFS, 32'h0);
    chk_val(rd, 32'h1);
    wait_sig(0, 200);
    chk_rng(n, 88, 95);
    apb(1'b0, ADCSC_RES_OFS, 32'h0);
    chk_val(rd, {22'h0, levels[ch*10 +: 10]});
    $display("channel change test done");
    levels[ch*10 +: 10] <= 10'h200;
    for (i = 0; i < 4; i++) begin
      apb(1'b1, ADCSC_PFM_OFS, 32'(8'h80 | ((i / 2) << 6)));
      apb(1'b1, ADCSC_PFT_OFS, {24'h0, pfv[i]});
      wait_sig(0, 150);
      chk_val(32'(n <= 150), 32'(pf_hit(10'h200, pfv[i], 1'(i / 2))));
    end
    apb(1'b1, ADCSC_PFM_OFS, 32'h0);
    $display("power fail test done");
    apb(1'b1, ADCSC_MODE_OFS, 32'h31);
    #1 chk_val({31'h0, conv_busy}, 32'h0);
    wait_sig(0, 150);
    chk_val(32'(n > 150), 32'h1);
    apb(1'b1, ADCSC_FLAG_OFS, 32'h1);
    apb(1'b0, ADCSC_FLAG_OFS, 32'h0);
    chk_val(rd, 32'h0);
    apb(1'b1, ADCSC_MODE_OFS, 32'hB1);
    repeat (10) @(posedge pclk);
    standby <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk_val({31'h0, conv_busy}, 32'h0);
    apb(1'b1, ADCSC_MODE_OFS, 32'h0);
    standby <= 1'b0;
    $display("stop and standby test done");
    tally_and_finish();
  end
endmodule : tb_adc_sequencing_control
